/* File: include/scs_pkg.sv */
// ****************************************************************
// system clock source select: shared constants and types
// ****************************************************************
package scs_pkg;

  // ****************************************************************
  // bus and timing
  // ****************************************************************
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          SYS_CLK_MHZ = 200;
  localparam int          PERIOD_W    = 16;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0]  SYSCFG_OFS  = 8'h00;
  localparam logic [7:0]  LOOPCFG_OFS = 8'h04;
  localparam logic [7:0]  STATUS_OFS  = 8'h08;

  // ****************************************************************
  // field positions and widths
  // ****************************************************************
  localparam int          SEL_LSB     = 0;
  localparam int          SEL_W       = 2;
  localparam int          PRE_LSB     = 16;
  localparam int          PRE_W       = 10;
  localparam int          BYP_BIT     = 0;
  localparam int          BAND_LSB    = 1;
  localparam int          BAND_W      = 2;
  localparam int          REFSEL_BIT  = 3;
  localparam int          LIN_LSB     = 4;
  localparam int          LIN_W       = 4;
  localparam int          LMUL_LSB    = 8;
  localparam int          LMUL_W      = 8;
  localparam int          LOUT_LSB    = 16;
  localparam int          LOUT_W      = 7;
  localparam int          K1_MAX      = 1024;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [1:0]  SEL_RST     = 2'h0;
  localparam logic [9:0]  PRE_RST     = 10'h000;
  localparam logic        BYP_RST     = 1'b1;
  localparam logic [1:0]  BAND_RST    = 2'h0;
  localparam logic        REFSEL_RST  = 1'b0;
  localparam logic [3:0]  LIN_RST     = 4'h0;
  localparam logic [7:0]  LMUL_RST    = 8'h00;
  localparam logic [6:0]  LOUT_RST    = 7'h00;
  // a small start keeps the first lock within a few oscillator half cycles
  localparam logic [15:0] VCOHALF_RST = 16'h0008;

  // ****************************************************************
  // source select codes
  // ****************************************************************
  localparam logic [1:0]  SEL_WAKE    = 2'h0;
  localparam logic [1:0]  SEL_SOURCE  = 2'h2;
  localparam logic [1:0]  SEL_DIRECT  = 2'h3;

  // ****************************************************************
  // oscillator bands, in MHz, and the matching half periods in sys_clk cycles
  // ****************************************************************
  localparam int          BAND0_VCO_MIN_MHZ = 50;
  localparam int          BAND0_VCO_MAX_MHZ = 110;
  localparam int          BAND1_VCO_MIN_MHZ = 100;
  localparam int          BAND1_VCO_MAX_MHZ = 160;
  localparam logic [15:0] BAND0_HALF_MIN = 16'(SYS_CLK_MHZ / (2 * BAND0_VCO_MAX_MHZ));
  localparam logic [15:0] BAND0_HALF_MAX = 16'(SYS_CLK_MHZ / (2 * BAND0_VCO_MIN_MHZ));
  localparam logic [15:0] BAND1_HALF_MIN = 16'(SYS_CLK_MHZ / (2 * BAND1_VCO_MAX_MHZ));
  localparam logic [15:0] BAND1_HALF_MAX = 16'(SYS_CLK_MHZ / (2 * BAND1_VCO_MIN_MHZ));

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    MODE_WAKE   = 4'b0001,
    MODE_PRESC  = 4'b0010,
    MODE_LOOP   = 4'b0100,
    MODE_DIRECT = 4'b1000
  } scs_mode_t;

  typedef enum logic [2:0] {
    SW_RUN   = 3'b001,
    SW_PARK  = 3'b010,
    SW_CATCH = 3'b100
  } scs_sw_t;

endpackage

/* File: rtl/scs_divider.sv */
`timescale 1ns/10ps
// ****************************************************************
// integer clock divider working on sampled source edges
// ****************************************************************
module scs_divider #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  // control
  input  wire logic         clear,
  input  wire logic [W-1:0] divField,
  // source
  input  wire logic         srcLevel,
  input  wire logic         srcRise,
  // divided output
  output logic              divOut
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W:0]   factor;
  logic [W:0]   highCnt;
  logic         divOut_q;

  // high phase is the larger half for odd factors
  assign factor  = {1'b0, divField} + (W+1)'(1);
  assign highCnt = (factor + (W+1)'(1)) >> 1;

  always_comb
  begin
    cnt_d = cnt_q;
    if (srcRise)
    begin
      // >= keeps a lowered factor from running past the wrap
      cnt_d = (cnt_q >= divField) ? '0 : cnt_q + W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_q <= '0;
    else if (clear)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      divOut_q <= 1'b0;
    else if (clear)
      divOut_q <= 1'b0;
    else if (divField == '0)
      divOut_q <= srcLevel;
    else
      divOut_q <= ({1'b0, cnt_d} < highCnt);
  end

  assign divOut = divOut_q;

endmodule // scs_divider

/* File: rtl/scs_clock_select.sv */
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - select code 11 drives the system clock straight from the direct clock input.
// - crystal bypass with divide factor 1 behaves like direct drive.
// - select 10 with bypass 1 divides crystal or internal source by K1.
// - K1 reaches 1024, giving the slowest system clock.
// - select 10 with bypass 0 enables the loop, which supplies the clock.
// - loop factor is N over P times K2, each field plus one.
// - loop reference is either the crystal input or the internal source.
// - loop pulls its oscillator toward target gradually, never jumping in frequency.
// - system clock is the loop oscillator divided by K2.
// - band 00 and 01 select oscillator ranges; codes 1x are reserved.
// - select code 00 runs the system clock from the wakeup source.
module scs_clock_select
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  // register port
  input  wire logic [scs_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [scs_pkg::DATA_W-1:0] regWrData,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output logic      [scs_pkg::DATA_W-1:0] regRdData,
  // clock source pins
  input  wire logic                      directClockIn,
  input  wire logic                      crystalIn,
  input  wire logic                      internalClockIn,
  input  wire logic                      wakeupClockIn,
  // system clock
  output logic                           sysClkOut
);

  import scs_pkg::*;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [SEL_W-1:0]   clockSourceSelect_q;
  logic [PRE_W-1:0]   prescalerDividerField_q;
  logic               oscillatorBypass_q;
  logic [BAND_W-1:0]  oscillatorBandSelect_q;
  logic               refSelect_q;
  logic [LIN_W-1:0]   loopInputDividerField_q;
  logic [LMUL_W-1:0]  loopMultiplierField_q;
  logic [LOUT_W-1:0]  loopOutputDividerField_q;
  logic               restart_q;
  logic [DATA_W-1:0]  rdData_q;
  logic               wrSys;
  logic               wrLoop;

  assign wrSys  = regWrite && (regAddr == SYSCFG_OFS);
  assign wrLoop = regWrite && (regAddr == LOOPCFG_OFS);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clockSourceSelect_q     <= SEL_RST;
      prescalerDividerField_q <= PRE_RST;
    end
    else if (wrSys)
    begin
      clockSourceSelect_q     <= regWrData[SEL_LSB +: SEL_W];
      prescalerDividerField_q <= regWrData[PRE_LSB +: PRE_W];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oscillatorBypass_q       <= BYP_RST;
      oscillatorBandSelect_q   <= BAND_RST;
      refSelect_q              <= REFSEL_RST;
      loopInputDividerField_q  <= LIN_RST;
      loopMultiplierField_q    <= LMUL_RST;
      loopOutputDividerField_q <= LOUT_RST;
    end
    else if (wrLoop)
    begin
      oscillatorBypass_q       <= regWrData[BYP_BIT];
      oscillatorBandSelect_q   <= regWrData[BAND_LSB +: BAND_W];
      refSelect_q              <= regWrData[REFSEL_BIT];
      loopInputDividerField_q  <= regWrData[LIN_LSB +: LIN_W];
      loopMultiplierField_q    <= regWrData[LMUL_LSB +: LMUL_W];
      loopOutputDividerField_q <= regWrData[LOUT_LSB +: LOUT_W];
    end
  end

  // ****************************************************************
  // pin synchronisers: three stages, a level counts once stages two and three agree
  // ****************************************************************
  logic [3:0] pinMeta_q;
  logic [3:0] pinSync2_q;
  logic [3:0] pinSync3_q;
  logic [3:0] pinLvl_q;
  logic [3:0] pinLvl_d;
  logic [3:0] pinRise;
  logic       dirLvl;
  logic       xtalLvl;
  logic       intLvl;
  logic       wakeLvl;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinMeta_q  <= 4'h0;
      pinSync2_q <= 4'h0;
      pinSync3_q <= 4'h0;
    end
    else
    begin
      pinMeta_q  <= {wakeupClockIn, internalClockIn, crystalIn, directClockIn};
      pinSync2_q <= pinMeta_q;
      pinSync3_q <= pinSync2_q;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pinLvl_d[i] = (pinSync2_q[i] == pinSync3_q[i]) ? pinSync3_q[i] : pinLvl_q[i];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      pinLvl_q <= 4'h0;
    else
      pinLvl_q <= pinLvl_d;
  end

  assign pinRise = pinLvl_d & ~pinLvl_q;
  assign dirLvl  = pinLvl_q[0];
  assign xtalLvl = pinLvl_q[1];
  assign intLvl  = pinLvl_q[2];
  assign wakeLvl = pinLvl_q[3];

  // ****************************************************************
  // mode decode
  // ****************************************************************
  scs_mode_t reqMode;
  scs_mode_t activeMode_q;
  scs_sw_t   swState_q;

  always_comb
  begin
    if (clockSourceSelect_q == SEL_DIRECT)
      reqMode = MODE_DIRECT;
    else if (clockSourceSelect_q == SEL_SOURCE && oscillatorBypass_q)
      reqMode = MODE_PRESC;
    else if (clockSourceSelect_q == SEL_SOURCE)
      reqMode = MODE_LOOP;
    else
      reqMode = MODE_WAKE;
  end

  // ****************************************************************
  // reference selection and period measurement
  // ****************************************************************
  logic                refLvl;
  logic                refRise;
  logic [PERIOD_W-1:0] refCnt_q;
  logic [PERIOD_W-1:0] refPeriod_q;

  assign refLvl  = refSelect_q ? intLvl : xtalLvl;
  assign refRise = refSelect_q ? pinRise[2] : pinRise[1];

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      refCnt_q    <= '0;
      refPeriod_q <= '1;
    end
    else if (refRise)
    begin
      refCnt_q    <= '0;
      refPeriod_q <= refCnt_q + PERIOD_W'(1);
    end
    else if (refCnt_q != '1)
      refCnt_q <= refCnt_q + PERIOD_W'(1);
  end

  // ****************************************************************
  // loop oscillator: half period target from P and N, K2 applied after
  // ****************************************************************
  localparam int MUL_W = PERIOD_W + LIN_W + 1;

  function automatic logic [PERIOD_W-1:0] halfTarget(
    input logic [PERIOD_W-1:0] per,
    input logic [LIN_W-1:0]    pf,
    input logic [LMUL_W-1:0]   nf
  );
    logic [MUL_W-1:0] num;
    logic [MUL_W-1:0] den;
    logic [MUL_W-1:0] q;
    num = MUL_W'(per) * (MUL_W'(pf) + MUL_W'(1));
    den = MUL_W'(nf) + MUL_W'(1);
    q   = (num / den) >> 1;
    if (q == '0)
      q = MUL_W'(1);
    if (q > MUL_W'({PERIOD_W{1'b1}}))
      q = MUL_W'({PERIOD_W{1'b1}});
    return q[PERIOD_W-1:0];
  endfunction

  logic [PERIOD_W-1:0] vcoTarget;
  logic [PERIOD_W-1:0] vcoHalf_q;
  logic [PERIOD_W-1:0] vcoCnt_q;
  logic                vcoLvl_q;
  logic                vcoRun;
  logic                vcoToggle;
  logic                loopLocked;
  logic                bandFault;

  // frequency of the oscillator is f_ref * N / P; K2 divides it below
  assign vcoTarget = halfTarget(refPeriod_q, loopInputDividerField_q, loopMultiplierField_q);
  assign vcoRun    = (reqMode == MODE_LOOP) || (activeMode_q == MODE_LOOP);
  assign vcoToggle = vcoRun && (vcoCnt_q >= vcoHalf_q - PERIOD_W'(1));
  assign loopLocked = (vcoHalf_q == vcoTarget);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      vcoCnt_q <= '0;
      vcoLvl_q <= 1'b0;
    end
    else if (!vcoRun)
    begin
      vcoCnt_q <= '0;
      vcoLvl_q <= 1'b0;
    end
    else if (vcoToggle)
    begin
      vcoCnt_q <= '0;
      vcoLvl_q <= ~vcoLvl_q;
    end
    else
      vcoCnt_q <= vcoCnt_q + PERIOD_W'(1);
  end

  // one step per oscillator half cycle so the frequency only drifts, never jumps
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      vcoHalf_q <= VCOHALF_RST;
    else if (vcoToggle && vcoHalf_q < vcoTarget)
      vcoHalf_q <= vcoHalf_q + PERIOD_W'(1);
    else if (vcoToggle && vcoHalf_q > vcoTarget)
      vcoHalf_q <= vcoHalf_q - PERIOD_W'(1);
  end

  // band check: reserved codes always fault, others flag an out-of-range oscillator
  always_comb
  begin
    if (oscillatorBandSelect_q[1])
      bandFault = 1'b1;
    else if (oscillatorBandSelect_q[0])
      bandFault = (vcoHalf_q < BAND1_HALF_MIN) || (vcoHalf_q > BAND1_HALF_MAX);
    else
      bandFault = (vcoHalf_q < BAND0_HALF_MIN) || (vcoHalf_q > BAND0_HALF_MAX);
  end

  // ****************************************************************
  // dividers: K1 prescaler and K2 loop output divider
  // ****************************************************************
  logic k1Out;
  logic k2Out;
  logic divClear;

  assign divClear = (swState_q == SW_PARK);

  // a field of zero passes the source through, matching direct drive
  scs_divider #(
    .W        (PRE_W)
  ) u_prescaler (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .clear    (divClear),
    .divField (prescalerDividerField_q),
    .srcLevel (refLvl),
    .srcRise  (refRise),
    .divOut   (k1Out)
  );

  scs_divider #(
    .W        (LOUT_W)
  ) u_loop_out_div (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .clear    (divClear),
    .divField (loopOutputDividerField_q),
    .srcLevel (vcoLvl_q),
    .srcRise  (vcoToggle && !vcoLvl_q),
    .divOut   (k2Out)
  );

  // ****************************************************************
  // glitch free switch-over
  // ****************************************************************
  logic srcOut;
  logic sysClk_q;

  always_comb
  begin
    case (activeMode_q)
      MODE_DIRECT: srcOut = dirLvl;
      MODE_PRESC:  srcOut = k1Out;
      MODE_LOOP:   srcOut = k2Out;
      default:     srcOut = wakeLvl;
    endcase
  end

  // any config write restarts the path; set wins over the park that clears it
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      restart_q <= 1'b0;
    else if (wrSys || wrLoop)
      restart_q <= 1'b1;
    else if (swState_q == SW_PARK)
      restart_q <= 1'b0;
  end

  // leave only from a low output, and resume only when the new source is low
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      swState_q    <= SW_RUN;
      activeMode_q <= MODE_WAKE;
    end
    else
    begin
      case (swState_q)
        SW_RUN:
        begin
          if ((reqMode != activeMode_q || restart_q) && !sysClk_q && !srcOut)
            swState_q <= SW_PARK;
        end
        SW_PARK:
        begin
          activeMode_q <= reqMode;
          swState_q    <= SW_CATCH;
        end
        SW_CATCH:
        begin
          if (!srcOut)
            swState_q <= SW_RUN;
        end
        default:
          swState_q <= SW_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      sysClk_q <= 1'b0;
    else if (swState_q == SW_RUN)
      sysClk_q <= srcOut;
    else
      sysClk_q <= 1'b0;
  end

  assign sysClkOut = sysClk_q;

  // ****************************************************************
  // read port: data stand for one cycle after the strobe, zero otherwise
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdData_q <= '0;
    else if (!regRead)
      rdData_q <= '0;
    else if (regAddr == SYSCFG_OFS)
    begin
      rdData_q <= '0;
      rdData_q[SEL_LSB +: SEL_W]     <= clockSourceSelect_q;
      rdData_q[PRE_LSB +: PRE_W]     <= prescalerDividerField_q;
    end
    else if (regAddr == LOOPCFG_OFS)
    begin
      rdData_q <= '0;
      rdData_q[BYP_BIT]              <= oscillatorBypass_q;
      rdData_q[BAND_LSB +: BAND_W]   <= oscillatorBandSelect_q;
      rdData_q[REFSEL_BIT]           <= refSelect_q;
      rdData_q[LIN_LSB +: LIN_W]     <= loopInputDividerField_q;
      rdData_q[LMUL_LSB +: LMUL_W]   <= loopMultiplierField_q;
      rdData_q[LOUT_LSB +: LOUT_W]   <= loopOutputDividerField_q;
    end
    else if (regAddr == STATUS_OFS)
      rdData_q <= {refPeriod_q, 8'h00, 1'b0, bandFault, loopLocked,
                   (swState_q != SW_RUN), activeMode_q};
    else
      rdData_q <= '0;
  end

  assign regRdData = rdData_q;

endmodule // scs_clock_select

/* File: dv/scs_source_model.sv */
`timescale 1ns/10ps
// ****
// clock source pins, counted off sys_clk so periods are exact
// ****
module scs_source_model #(
  parameter int DIR_H  = 6,
  parameter int XTAL_H = 4,
  parameter int INT_H  = 5,
  parameter int WAKE_H = 9
) (
  // clock
  input  wire logic sys_clk,
  // source pins
  output logic      directClockIn,
  output logic      crystalIn,
  output logic      internalClockIn,
  output logic      wakeupClockIn
);
  int cnt = 0;
  initial {directClockIn, crystalIn, internalClockIn, wakeupClockIn} = 4'h0;
  // oscillators run free, so they toggle outside any frame too
  always @(posedge sys_clk)
  begin
    cnt <= cnt + 1;
    if (cnt % DIR_H == DIR_H - 1) directClockIn <= ~directClockIn;
    if (cnt % XTAL_H == XTAL_H - 1) crystalIn <= ~crystalIn;
    if (cnt % INT_H == INT_H - 1) internalClockIn <= ~internalClockIn;
    if (cnt % WAKE_H == WAKE_H - 1) wakeupClockIn <= ~wakeupClockIn;
  end
endmodule // scs_source_model

/* File: dv/scs_clock_select_checker.sv */
`timescale 1ns/10ps
// ****
// port checker
// ****
module scs_clock_select_checker
  import scs_pkg::*;
#(
  parameter int XTAL_PER = 8,
  parameter int INT_PER  = 10
) (
  input wire logic                       sys_clk,
  input wire logic                       reset_n,
  input wire logic [scs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [scs_pkg::DATA_W-1:0] regWrData,
  input wire logic                       regWrite,
  input wire logic                       regRead,
  input wire logic [scs_pkg::DATA_W-1:0] regRdData,
  input wire logic                       directClockIn,
  input wire logic                       crystalIn,
  input wire logic                       internalClockIn,
  input wire logic                       wakeupClockIn,
  input wire logic                       sysClkOut
);
  logic [1:0]  selQ;
  logic [9:0]  k1Q;
  logic        bypQ;
  logic        refQ;
  logic        noLoopQ;
  logic [15:0] sinceQ;
  logic [15:0] perQ;
  logic [1:0]  riseQ;
  logic        wrHit;
  logic        settled;
  logic        presc;
  int          srcPer;
  assign wrHit   = regWrite && (regAddr == SYSCFG_OFS || regAddr == LOOPCFG_OFS);
  assign settled = sinceQ >= 16'h0040 && riseQ == 2'h3;
  assign presc   = selQ == SEL_SOURCE && bypQ;
  assign srcPer  = refQ ? INT_PER : XTAL_PER;
  // shadow of the configuration, so modes can be judged from the ports alone
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) {selQ, k1Q, bypQ, refQ} <= {SEL_RST, PRE_RST, BYP_RST, REFSEL_RST};
    else if (regWrite && regAddr == SYSCFG_OFS) {selQ, k1Q} <= {regWrData[1:0], regWrData[25:16]};
    else if (regWrite && regAddr == LOOPCFG_OFS) {bypQ, refQ} <= {regWrData[0], regWrData[3]};
  // loop clock may legally start with short phases, so pulse width is judged only before it
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) noLoopQ <= 1'b1;
    else if (selQ == SEL_SOURCE && !bypQ) noLoopQ <= 1'b0;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) sinceQ <= 16'h0000;
    else if (wrHit) sinceQ <= 16'h0000;
    else if (sinceQ != 16'hFFFF) sinceQ <= sinceQ + 16'h0001;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) riseQ <= 2'h0;
    else if (wrHit) riseQ <= 2'h0;
    else if ($rose(sysClkOut) && riseQ != 2'h3) riseQ <= riseQ + 2'h1;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) perQ <= 16'h0000;
    else if ($rose(sysClkOut)) perQ <= 16'h0001;
    else perQ <= perQ + 16'h0001;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_pass_rise; ##[3:8] $rose(sysClkOut); endsequence
  sequence s_pass_fall; ##[3:8] $fell(sysClkOut); endsequence
  sequence s_hold_high; sysClkOut [*2]; endsequence
  sequence s_hold_low; !sysClkOut [*2]; endsequence

  property p_direct_rise; settled && selQ == SEL_DIRECT && $rose(directClockIn) |-> s_pass_rise; endproperty
  property p_direct_fall; settled && selQ == SEL_DIRECT && $fell(directClockIn) |-> s_pass_fall; endproperty
  property p_wake_rise; settled && selQ == SEL_WAKE && $rose(wakeupClockIn) |-> s_pass_rise; endproperty
  property p_pass_k1; settled && presc && k1Q == 10'h000 && !refQ && $rose(crystalIn) |-> s_pass_rise; endproperty
  property p_presc_period; settled && presc && $rose(sysClkOut) |-> int'(perQ) == (int'(k1Q) + 1) * srcPer; endproperty
  property p_presc_high;
    settled && presc && k1Q != 10'h000 && $fell(sysClkOut) |-> int'(perQ) == ((int'(k1Q) + 2) / 2) * srcPer;
  endproperty
  property p_min_high; noLoopQ && $rose(sysClkOut) |-> s_hold_high; endproperty
  property p_min_low; noLoopQ && $fell(sysClkOut) |-> s_hold_low; endproperty

  a_direct_rise: assert property (p_direct_rise) else $error("direct rise not passed");
  a_direct_fall: assert property (p_direct_fall) else $error("direct fall not passed");
  a_wake_rise: assert property (p_wake_rise) else $error("wakeup rise not passed");
  a_pass_k1: assert property (p_pass_k1) else $error("divide by one not pass-through");
  a_presc_period: assert property (p_presc_period) else $error("prescaler period wrong");
  a_presc_high: assert property (p_presc_high) else $error("prescaler high phase wrong");
  a_min_high: assert property (p_min_high) else $error("short high phase");
  a_min_low: assert property (p_min_low) else $error("short low phase");
endmodule // scs_clock_select_checker

bind scs_clock_select scs_clock_select_checker i_scs_clock_select_checker (.*);

/* File: dv/system_clock_source_select_test.sv */
`timescale 1ns/10ps
// ****
// random and corner tests of source selection
// ****
module system_clock_source_select_test;
  import scs_pkg::*;
  localparam int XP = 8;
  localparam int IP = 10;
  logic              sys_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              regWrite = 1'b0;
  logic              regRead = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic [DATA_W-1:0] regRdData;
  logic [DATA_W-1:0] rd;
  logic [31:0]       seed = 32'h948B;
  logic              dirIn, xtalIn, intIn, wakeIn, sysClkOut;
  int                miscompares = 0;
  int                numChecks = 0;
  int                per;
  initial forever #2.5 sys_clk = ~sys_clk;
  scs_source_model i_scs_source_model (.sys_clk(sys_clk), .directClockIn(dirIn), .crystalIn(xtalIn),
    .internalClockIn(intIn), .wakeupClockIn(wakeIn));
  scs_clock_select i_scs_clock_select (.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .directClockIn(dirIn), .crystalIn(xtalIn), .internalClockIn(intIn), .wakeupClockIn(wakeIn),
    .sysClkOut(sysClkOut));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic summarize;
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {regWrite, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdT(input logic [7:0] a);
    @(posedge sys_clk);
    {regRead, regAddr} <= {1'b1, a};
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 rd = regRdData;
  endtask
  // period between the second and third rise seen, so the first partial phase is skipped
  task automatic getPer(input int lim);
    int n, r;
    logic p;
    r = 0;
    per = 0;
    p = sysClkOut;
    for (n = 0; n < lim && r < 3; n++)
    begin
      @(posedge sys_clk);
      #1;
      if (sysClkOut && !p) r++;
      if (r == 2) per++;
      p = sysClkOut;
    end
    if (r < 3)
    begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic modeChk(input logic [31:0] sc, input logic [31:0] lc, input int expPer, input logic [3:0] md);
    wr(LOOPCFG_OFS, lc);
    wr(SYSCFG_OFS, sc);
    repeat (64) @(posedge sys_clk);
    getPer(4 * expPer + 2000);
    chk("period", per, expPer);
    rdT(STATUS_OFS);
    chk("mode", rd[3:0], md);
  endtask
  task automatic pollStat(input int bitNo);
    int n;
    for (n = 0; n < 6000; n++)
    begin
      rdT(STATUS_OFS);
      if (rd[bitNo] === 1'b1) break;
    end
    chk("status bit", rd[bitNo], 1'b1);
  endtask
  initial
  begin
    int i, k, r;
    logic [31:0] d;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdT(SYSCFG_OFS);
    chk("syscfg reset", rd, 32'h0000_0000);
    rdT(LOOPCFG_OFS);
    chk("loopcfg reset", rd, 32'h0000_0001);
    rdT(8'h0C);
    chk("unmapped", rd, 32'h0000_0000);
    wr(STATUS_OFS, 32'hFFFF_FFFF);
    rdT(STATUS_OFS);
    chk("status mode", rd[3:0], 4'h1);
    for (i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      d = seed & 32'h03FF_0003;
      d[1] = d[0];
      wr(SYSCFG_OFS, d);
      rdT(SYSCFG_OFS);
      chk("syscfg", rd, d);
      seed = xs(seed);
      d = (seed & 32'h007F_FFFF) | 32'h1;
      wr(LOOPCFG_OFS, d);
      rdT(LOOPCFG_OFS);
      chk("loopcfg", rd, d);
    end
    modeChk(32'h3, 32'h1, 12, 4'h8);
    modeChk(32'h0, 32'h1, 18, 4'h1);
    for (i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      k = (i == 0) ? 0 : (i == 5) ? 1023 : int'(seed[3:0]);
      r = (i == 1 || i == 3) ? 1 : 0;
      modeChk(32'h2 | (k << 16), 32'h1 | (r << 3), (k + 1) * (r ? IP : XP), 4'h2);
    end
    for (r = 0; r < 2; r++)
    begin
      wr(LOOPCFG_OFS, 32'h0001_0000 | (r << 3));
      wr(SYSCFG_OFS, 32'h2);
      pollStat(5);
      // K1 is zero and the loop has locked by now, so only the settled K2 output period is measured
      getPer(10000);
      chk("loop period", per, 2 * 2 * ((r ? IP : XP) / 2));
      rdT(STATUS_OFS);
      chk("loop mode", rd[3:0], 4'h4);
    end
    wr(LOOPCFG_OFS, 32'h0001_0004);
    pollStat(6);
    summarize();
  end
endmodule // system_clock_source_select_test
